// [hw/ect_top.sv]
// Contract
// - eight 32-bit counters plus one shared timer
// - timer interval one microsecond to 1e6 s
// - count limit one to 4,294,967 kilocounts
// - only channel seven compares against preset
// - start rising edge begins counting
// - stop rising edge ends; open inputs low
// - start ignored after limit until cleared
// - gate low pauses counting; open gate high
// - run output high while counting
// - switches invert start, stop, gate, run
// - indicator lit while counting gate open
// - snapshots on gate or clock, 10000 deep
// - count-limit mode stops at channel seven preset
// - timer-limit stop, ignored in gate acquisition
// - run only when started and gate high
// - off after reset; stop mode kept
`timescale 1ns/100ps
`default_nettype none
`include "ect_defs.svh"

module ect_top
   import ect_pkg::*;
#(
   parameter int NCH = 8,
   parameter int CW = 32,
   parameter int TW = 40,
   parameter int DEPTH = 10000,
   parameter int AW = 14
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [NCH-1:0] cnt_in,
   input wire logic start_in,
   input wire logic stop_in,
   input wire logic gate_in,
   input wire logic [3:0] polarity_switch_bank,
   input wire logic [1:0] nv_stop_mode,
   output logic [1:0] stop_mode_out,
   output logic run_out,
   output logic led_out,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);

   localparam int TICK_CYC = `ECT_TICK_CYC;
   localparam int PRESET_LIMIT_CHANNEL = NCH - 1;

   initial
   begin
      if (NCH != 8 || CW != 32 || TW < 40 || TW > 64 || TICK_CYC < 1 || TICK_CYC > 128)
         $error("ect_top: unsupported parameters");
   end

   // ****************************************
   // input synchronisation
   // ****************************************
   logic [NCH-1:0] s_cnt;
   ect_ctl_t s_ctl;
   logic [3:0] s_pol;

   ect_sync #(.W(NCH + 7)) u_sync (
      .sys_clk(sys_clk),
      .rst(rst),
      .ce(ce),
      .d({polarity_switch_bank, gate_in, stop_in, start_in, cnt_in}),
      .q({s_pol, s_ctl, s_cnt})
   );

   // switch high = active high, switch low inverts
   ect_ctl_t lvl;
   assign lvl.start = s_ctl.start ^ ~s_pol[`ECT_POL_START];
   assign lvl.stop = s_ctl.stop ^ ~s_pol[`ECT_POL_STOP];
   assign lvl.gate = s_ctl.gate ^ ~s_pol[`ECT_POL_GATE];

   // ****************************************
   // control state
   // ****************************************
   logic run_r, run_nxt;
   ect_ctl_t prev_r;
   logic [NCH-1:0] cprev_r;
   logic [6:0] presc_r, presc_nxt;
   logic [TW-1:0] tmr_r, tmr_nxt;
   logic [CW-1:0] cnt_r [NCH];
   ect_stop_mode_t mode_r, mode_nxt;
   ect_acq_mode_t acq_r, acq_nxt;
   logic [31:0] cpre_r, cpre_nxt, on_r, on_nxt, off_r, off_nxt;
   logic [TW-1:0] tpre_r, tpre_nxt;
   ect_phase_t ph_r, ph_nxt;
   logic [31:0] phc_r, phc_nxt;
   logic [AW-1:0] waddr_r, waddr_nxt, end_r, end_nxt, raddr_r, raddr_nxt;
   logic [2:0] rsel_r, rsel_nxt;
   logic eff_prev_r;
   logic run_out_r, led_r;
   logic [31:0] rdata_r, rdata_nxt;

   logic start_edge, stop_edge, tick, act, lim_cnt, lim_tmr, lim_hit;
   logic cmd_start, cmd_stop, clr_all, clr_ch7, clr_tmr, clr_addr;
   logic eff_gate, snap, acq_done;
   logic [NCH*CW-1:0] snap_data, acq_rd;
   logic [NCH-1:0] clr_ch;

   logic wr_ctrl;
   assign wr_ctrl = wr && addr == `ECT_A_CTRL;
   assign cmd_start = wr_ctrl && wdata[`ECT_CTRL_START];
   assign cmd_stop = wr_ctrl && wdata[`ECT_CTRL_STOP];
   assign clr_all = wr_ctrl && wdata[`ECT_CTRL_CLR_ALL];
   assign clr_ch7 = wr_ctrl && wdata[`ECT_CTRL_CLR_CH7];
   assign clr_tmr = wr_ctrl && wdata[`ECT_CTRL_CLR_TMR];
   assign clr_addr = wr_ctrl && wdata[`ECT_CTRL_CLR_ADDR];

   // edges found on synchronised, polarity-corrected levels
   assign start_edge = lvl.start && !prev_r.start;
   assign stop_edge = lvl.stop && !prev_r.stop;

   // ****************************************
   // limits and activity
   // ****************************************
   assign lim_cnt = mode_r == count_limit_stop_cmd
                    && cnt_r[PRESET_LIMIT_CHANNEL] >= cpre_r;
   assign lim_tmr = mode_r == time_limit_stop_cmd && acq_r != ect_acq_gate
                    && tmr_r >= tpre_r;
   assign lim_hit = lim_cnt || lim_tmr;

   assign eff_gate = acq_r == ect_acq_clock ? ph_r == ect_ph_on : lvl.gate;
   assign act = run_r && lvl.gate && (acq_r != ect_acq_clock || ph_r == ect_ph_on);
   assign tick = run_r && presc_r == 7'(TICK_CYC - 1);
   assign snap = run_r && acq_r != ect_acq_off && eff_gate != eff_prev_r;
   assign acq_done = snap && (waddr_r == end_r || int'(waddr_r) == DEPTH - 1);

   always_comb
   begin
      run_nxt = run_r;
      if (stop_edge || cmd_stop || lim_hit || acq_done)
         run_nxt = 1'b0;
      else if ((start_edge || cmd_start) && !lim_hit)
         run_nxt = 1'b1;
      presc_nxt = (!run_r || tick) ? 7'h00 : presc_r + 7'h01;
      tmr_nxt = tmr_r;
      if (clr_all || clr_tmr)
         tmr_nxt = '0;
      else if (tick && act)
         tmr_nxt = tmr_r + 1'b1;
   end

   // ****************************************
   // counter channels
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < NCH; g++)
      begin : g_ch
         logic [CW-1:0] c_nxt;
         assign clr_ch[g] = clr_all || (g == PRESET_LIMIT_CHANNEL && clr_ch7)
                            || (wr && addr[7:5] == `ECT_A_CNT_BASE && int'(addr[4:2]) == g);
         assign snap_data[g*CW +: CW] = cnt_r[g];
         always_comb
         begin
            c_nxt = cnt_r[g];
            if (clr_ch[g])
               c_nxt = '0;
            else if (act && s_cnt[g] && !cprev_r[g])
               c_nxt = cnt_r[g] + 1'b1;
         end
         always_ff @(posedge sys_clk)
         begin
            if (rst)
               cnt_r[g] <= '0;
            else if (ce)
               cnt_r[g] <= c_nxt;
         end
      end
   endgenerate

   // ****************************************
   // internal on/off clock for acquisition
   // ****************************************
   always_comb
   begin
      ph_nxt = ph_r;
      phc_nxt = phc_r;
      case (ph_r)
         ect_ph_idle:
         begin
            phc_nxt = 32'h0000_0000;
            if (run_r && acq_r == ect_acq_clock)
               ph_nxt = ect_ph_on;
         end
         ect_ph_on, ect_ph_off:
         begin
            if (!run_r || acq_r != ect_acq_clock)
               ph_nxt = ect_ph_idle;
            else if (tick)
            begin
               phc_nxt = phc_r + 32'h0000_0001;
               if (phc_nxt >= (ph_r == ect_ph_on ? on_r : off_r))
               begin
                  phc_nxt = 32'h0000_0000;
                  ph_nxt = ph_r == ect_ph_on ? ect_ph_off : ect_ph_on;
               end
            end
         end
         default: ph_nxt = ect_ph_idle;
      endcase
      waddr_nxt = waddr_r;
      if (clr_addr)
         waddr_nxt = '0;
      else if (snap && !acq_done)
         waddr_nxt = waddr_r + 1'b1;
   end

   // storage shared by gate and clock acquisition
   ect_acq #(.W(NCH * CW), .DEPTH(DEPTH), .AW(AW)) u_acq (
      .sys_clk(sys_clk),
      .ce(ce),
      .wr_en(snap),
      .wr_addr(waddr_r),
      .wr_data(snap_data),
      .rd_addr(raddr_r),
      .rd_data(acq_rd)
   );

   // ****************************************
   // register bus
   // ****************************************
   always_comb
   begin
      mode_nxt = mode_r;
      acq_nxt = acq_r;
      cpre_nxt = cpre_r;
      tpre_nxt = tpre_r;
      on_nxt = on_r;
      off_nxt = off_r;
      end_nxt = end_r;
      raddr_nxt = raddr_r;
      rsel_nxt = rsel_r;
      if (wr)
      begin
         case (addr)
            `ECT_A_MODE:
            begin
               mode_nxt = wdata[1:0] == 2'h3 ? no_auto_stop_cmd
                          : ect_stop_mode_t'(wdata[`ECT_MODE_STOP_LSB +: 2]);
               acq_nxt = wdata[3:2] == 2'h3 ? ect_acq_off
                         : ect_acq_mode_t'(wdata[`ECT_MODE_ACQ_LSB +: 2]);
            end
            `ECT_A_CPRE: cpre_nxt = wdata == 32'h0 ? 32'h1 : wdata;
            `ECT_A_TPRE_LO: tpre_nxt[31:0] = wdata;
            `ECT_A_TPRE_HI: tpre_nxt[TW-1:32] = wdata[TW-33:0];
            `ECT_A_ON_TIME: on_nxt = wdata;
            `ECT_A_OFF_TIME: off_nxt = wdata;
            `ECT_A_ACQ_END: end_nxt = wdata[AW-1:0];
            `ECT_A_ACQ_SEL:
            begin
               raddr_nxt = wdata[AW-1:0];
               rsel_nxt = wdata[18:16];
            end
            default: ;
         endcase
      end
      rdata_nxt = 32'h0000_0000;
      if (rd)
      begin
         if (addr[7:5] == `ECT_A_CNT_BASE)
            rdata_nxt = cnt_r[addr[4:2]];
         else
         begin
            case (addr)
               `ECT_A_CTRL: rdata_nxt = {29'h0, lim_hit, act, run_r};
               `ECT_A_MODE: rdata_nxt = {28'h0, acq_r, mode_r};
               `ECT_A_CPRE: rdata_nxt = cpre_r;
               `ECT_A_TPRE_LO: rdata_nxt = tpre_r[31:0];
               `ECT_A_TPRE_HI: rdata_nxt = 32'(tpre_r[TW-1:32]);
               `ECT_A_ON_TIME: rdata_nxt = on_r;
               `ECT_A_OFF_TIME: rdata_nxt = off_r;
               `ECT_A_ACQ_ADDR: rdata_nxt = 32'(waddr_r);
               `ECT_A_ACQ_END: rdata_nxt = 32'(end_r);
               `ECT_A_ACQ_SEL: rdata_nxt = {13'h0, rsel_r, 2'h0, raddr_r};
               `ECT_A_ACQ_DATA: rdata_nxt = acq_rd[rsel_r*CW +: CW];
               `ECT_A_TMR_LO: rdata_nxt = tmr_r[31:0];
               `ECT_A_TMR_HI: rdata_nxt = 32'(tmr_r[TW-1:32]);
               default: rdata_nxt = 32'h0000_0000;
            endcase
         end
      end
   end

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         run_r <= 1'b0;
         prev_r <= '1; // no false start edge while the synchronisers fill
         cprev_r <= '0;
         presc_r <= 7'h00;
         tmr_r <= '0;
         // stop mode reloaded from the keep-alive store on every reset
         mode_r <= nv_stop_mode == 2'h3 ? no_auto_stop_cmd : ect_stop_mode_t'(nv_stop_mode);
         acq_r <= ect_acq_off;
         cpre_r <= `ECT_CPRE_RST;
         tpre_r <= TW'(`ECT_TPRE_RST);
         on_r <= `ECT_ON_RST;
         off_r <= `ECT_OFF_RST;
         ph_r <= ect_ph_idle;
         phc_r <= 32'h0000_0000;
         waddr_r <= '0;
         end_r <= AW'(`ECT_END_RST);
         raddr_r <= '0;
         rsel_r <= 3'h0;
         eff_prev_r <= 1'b0;
         run_out_r <= 1'b0;
         led_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end
      else if (ce)
      begin
         run_r <= run_nxt;
         prev_r <= lvl;
         cprev_r <= s_cnt;
         presc_r <= presc_nxt;
         tmr_r <= tmr_nxt;
         mode_r <= mode_nxt;
         acq_r <= acq_nxt;
         cpre_r <= cpre_nxt;
         tpre_r <= tpre_nxt;
         on_r <= on_nxt;
         off_r <= off_nxt;
         ph_r <= ph_nxt;
         phc_r <= phc_nxt;
         waddr_r <= waddr_nxt;
         end_r <= end_nxt;
         raddr_r <= raddr_nxt;
         rsel_r <= rsel_nxt;
         eff_prev_r <= eff_gate;
         run_out_r <= act ^ ~s_pol[`ECT_POL_RUN];
         led_r <= act;
         rdata_r <= rdata_nxt;
      end
   end

   assign run_out = run_out_r;
   assign led_out = led_r;
   assign rdata = rdata_r;
   assign stop_mode_out = mode_r;

   // ****************************************
   // checks
   // ****************************************
   sequence seq_start_taken;
      ce && start_edge && !lim_hit && !stop_edge && !cmd_stop && !acq_done;
   endsequence

   chk_start_begins: assert property (@(posedge sys_clk) disable iff (rst)
      seq_start_taken |=> run_r)
      else $error("start edge did not begin counting");
   chk_stop_ends: assert property (@(posedge sys_clk) disable iff (rst)
      ce && stop_edge |=> !run_r)
      else $error("stop edge did not end counting");
   chk_limit_block: assert property (@(posedge sys_clk) disable iff (rst)
      ce && lim_hit && !run_r |=> !run_r)
      else $error("start accepted past limit");
   chk_gate_pause: assert property (@(posedge sys_clk) disable iff (rst)
      ce && !lvl.gate && !clr_ch[0] && !clr_tmr |=> $stable(cnt_r[0]) && $stable(tmr_r))
      else $error("count moved while gate low");
   chk_run_gate: assert property (@(posedge sys_clk) disable iff (rst)
      ce |=> run_out_r == (($past(run_r) && $past(lvl.gate)
          && ($past(acq_r) != ect_acq_clock || $past(ph_r) == ect_ph_on)) ^ ~$past(s_pol[3])))
      else $error("run output does not follow count and gate");
   chk_count_limit: assert property (@(posedge sys_clk) disable iff (rst)
      ce && mode_r == count_limit_stop_cmd && cnt_r[7] >= cpre_r |=> !run_r)
      else $error("count limit did not stop counting");
   chk_timer_limit: assert property (@(posedge sys_clk) disable iff (rst)
      ce && mode_r == time_limit_stop_cmd && acq_r == ect_acq_gate && run_r
      && !stop_edge && !cmd_stop && !lim_cnt && !acq_done |=> run_r)
      else $error("timer limit acted during gate acquisition");
   chk_ch7_count: assert property (@(posedge sys_clk) disable iff (rst)
      ce && !clr_ch[7] |=> cnt_r[7] == $past(cnt_r[7])
                + CW'($past(act) && $past(s_cnt[7]) && !$past(cprev_r[7])))
      else $error("channel seven count step wrong");
   chk_led_follows: assert property (@(posedge sys_clk) disable iff (rst)
      ce && act |=> led_r)
      else $error("indicator dark while counting");

endmodule
`default_nettype wire

// [hw/ect_defs.svh]
`ifndef ECT_DEFS_SVH
`define ECT_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define ECT_A_CTRL 8'h00
`define ECT_A_MODE 8'h04
`define ECT_A_CPRE 8'h08
`define ECT_A_TPRE_LO 8'h0c
`define ECT_A_TPRE_HI 8'h10
`define ECT_A_ON_TIME 8'h14
`define ECT_A_OFF_TIME 8'h18
`define ECT_A_ACQ_ADDR 8'h1c
`define ECT_A_ACQ_END 8'h20
`define ECT_A_ACQ_SEL 8'h24
`define ECT_A_ACQ_DATA 8'h28
`define ECT_A_TMR_LO 8'h60
`define ECT_A_TMR_HI 8'h64
`define ECT_A_CNT_BASE 3'h2

// ****************************************
// field positions
// ****************************************
`define ECT_CTRL_START 0
`define ECT_CTRL_STOP 1
`define ECT_CTRL_CLR_ALL 2
`define ECT_CTRL_CLR_CH7 3
`define ECT_CTRL_CLR_TMR 4
`define ECT_CTRL_CLR_ADDR 5
`define ECT_MODE_STOP_LSB 0
`define ECT_MODE_ACQ_LSB 2
`define ECT_POL_START 0
`define ECT_POL_STOP 1
`define ECT_POL_GATE 2
`define ECT_POL_RUN 3

// ****************************************
// reset values
// ****************************************
`define ECT_CPRE_RST 32'h0000_0001
`define ECT_TPRE_RST 40'h00_0000_0001
`define ECT_ON_RST 32'h0000_0001
`define ECT_OFF_RST 32'h0000_0001
`define ECT_END_RST 14'h270f

// ****************************************
// timing
// ****************************************
`define ECT_CLK_PERIOD_NS 10
`define ECT_TICK_NS 1000
`define ECT_TICK_CYC (`ECT_TICK_NS / `ECT_CLK_PERIOD_NS)

`endif

// [hw/ect_pkg.sv]
package ect_pkg;

   typedef enum logic [1:0] {
      no_auto_stop_cmd,
      count_limit_stop_cmd,
      time_limit_stop_cmd
   } ect_stop_mode_t;

   typedef enum logic [1:0] {
      ect_acq_off,
      ect_acq_gate,
      ect_acq_clock
   } ect_acq_mode_t;

   typedef enum logic [1:0] {
      ect_ph_idle,
      ect_ph_on,
      ect_ph_off
   } ect_phase_t;

   typedef struct packed {
      logic gate;
      logic stop;
      logic start;
   } ect_ctl_t;

endpackage

// [hw/ect_sync.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// two-stage synchroniser bank
// ****************************************
module ect_sync
   import ect_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   initial
   begin
      if (W < 1)
         $error("ect_sync: W must be at least 1");
   end

   // first stage feeds only the second
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         meta_r <= '0;
         q_r <= '0;
      end
      else if (ce)
      begin
         meta_r <= d;
         q_r <= meta_r;
      end
   end

   assign q = q_r;

endmodule
`default_nettype wire

// [hw/ect_acq.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// snapshot store
// ****************************************
module ect_acq
   import ect_pkg::*;
#(
   parameter int W = 256,
   parameter int DEPTH = 10000,
   parameter int AW = 14
)
(
   input wire logic sys_clk,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);

   logic [W-1:0] mem [DEPTH];
   logic [W-1:0] rd_data_r;

   initial
   begin
      if (DEPTH < 1 || DEPTH > (1 << AW))
         $error("ect_acq: DEPTH does not fit AW");
   end

   // no reset on the array: contents are only defined once written
   always_ff @(posedge sys_clk)
   begin
      if (ce)
      begin
         if (wr_en && int'(wr_addr) < DEPTH)
            mem[wr_addr] <= wr_data;
         if (int'(rd_addr) < DEPTH)
            rd_data_r <= mem[rd_addr];
         else
            rd_data_r <= '0;
      end
   end

   assign rd_data = rd_data_r;

endmodule
`default_nettype wire

// [dv/ect_far_side.sv]
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// far-side trigger sources and pulse feeds
// ****************************************
module ect_far_side
   import ect_pkg::*;
(
   input wire logic sys_clk,
   input wire logic [3:0] pol,
   output logic start_in,
   output logic stop_in,
   output logic gate_in,
   output logic [7:0] cnt_in
);
   logic [1:0] trig_act = 2'h0;
   logic gate_open = 1'b1;
   logic [7:0] cnt_r = 8'h00;

   // idle start and stop sit inactive and the gate sits open, like an open pin on the board
   assign start_in = trig_act[0] ~^ pol[0];
   assign stop_in = trig_act[1] ~^ pol[1];
   assign gate_in = gate_open ~^ pol[2];
   assign cnt_in = cnt_r;

   // 11 cycles keeps the pulse above the 100 ns minimum
   task automatic pulse_trig(input int b);
      @(posedge sys_clk);
      trig_act[b] <= 1'b1;
      repeat (11) @(posedge sys_clk);
      trig_act[b] <= 1'b0;
      repeat (8) @(posedge sys_clk);
   endtask

   task automatic set_gate(input logic v);
      @(posedge sys_clk);
      gate_open <= v;
      repeat (6) @(posedge sys_clk);
   endtask

   // two high, two low: each edge survives the synchroniser
   task automatic pulse_cnt(input int ch, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         cnt_r[ch] <= 1'b1;
         repeat (2) @(posedge sys_clk);
         cnt_r[ch] <= 1'b0;
         @(posedge sys_clk);
      end
      repeat (6) @(posedge sys_clk);
   endtask
endmodule

`default_nettype wire

// [dv/ect_top_bench.sv]
`timescale 1ns/100ps
`default_nettype none
`include "ect_defs.svh"

module ect_top_bench
   import ect_pkg::*;
;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [1:0] nv_stop_mode = 2'h0;
   logic [3:0] bank = 4'hf;
   logic [31:0] rdata;
   logic [1:0] stop_mode_out;
   logic run_out, led_out, start_in, stop_in, gate_in;
   logic [7:0] cnt_in;
   int fail_count = 0;
   int total_checks = 0;

   always #5 sys_clk = ~sys_clk;

   ect_far_side u_ect_far_side (.sys_clk(sys_clk), .pol(bank), .start_in(start_in),
      .stop_in(stop_in), .gate_in(gate_in), .cnt_in(cnt_in));

   ect_top u_ect_top (.sys_clk(sys_clk), .rst(rst), .ce(ce), .cnt_in(cnt_in),
      .start_in(start_in), .stop_in(stop_in), .gate_in(gate_in),
      .polarity_switch_bank(bank), .nv_stop_mode(nv_stop_mode),
      .stop_mode_out(stop_mode_out), .run_out(run_out), .led_out(led_out),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));

   // ****************************************
   // shared helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask

   // rdata stands only in the cycle after the read strobe
   task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
      logic [31:0] d;
      reg_rd(a, d);
      chk(d, exp, msg);
   endtask

   task automatic run_chk(input logic r, input logic l, input string msg);
      repeat (4) @(posedge sys_clk);
      #1 chk({31'h0, run_out}, {31'h0, r}, msg);
      chk({31'h0, led_out}, {31'h0, l}, msg);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_pins_count();
      reg_wr(`ECT_A_CTRL, 32'h4);
      u_ect_far_side.pulse_trig(0);
      run_chk(1'b1, 1'b1, "run after start");
      for (int ch = 0; ch < 8; ch++)
         u_ect_far_side.pulse_cnt(ch, ch + 1);
      u_ect_far_side.pulse_trig(1);
      run_chk(1'b0, 1'b0, "run after stop");
      u_ect_far_side.pulse_cnt(0, 2);
      for (int ch = 0; ch < 8; ch++)
         rd_chk(8'h40 + 8'(4 * ch), 32'(ch + 1), "channel count");
      rd_chk(8'h3c, 32'h0, "unmapped read");
      $display("test pins_count done");
   endtask

   task automatic t_gate();
      reg_wr(`ECT_A_CTRL, 32'h4);
      u_ect_far_side.pulse_trig(0);
      u_ect_far_side.set_gate(1'b0);
      run_chk(1'b0, 1'b0, "run with gate low");
      u_ect_far_side.pulse_cnt(1, 3);
      u_ect_far_side.set_gate(1'b1);
      run_chk(1'b1, 1'b1, "run with gate back");
      u_ect_far_side.pulse_cnt(1, 2);
      rd_chk(8'h44, 32'h2, "gated count");
      u_ect_far_side.pulse_trig(1);
      $display("test gate done");
   endtask

   task automatic t_count_limit();
      reg_wr(`ECT_A_MODE, 32'(count_limit_stop_cmd));
      reg_wr(`ECT_A_CPRE, 32'h3);
      reg_wr(`ECT_A_CTRL, 32'h4);
      #1 chk({30'h0, stop_mode_out}, 32'(count_limit_stop_cmd), "mode out");
      u_ect_far_side.pulse_trig(0);
      u_ect_far_side.pulse_cnt(0, 5);
      u_ect_far_side.pulse_cnt(7, 2);
      run_chk(1'b1, 1'b1, "below preset");
      u_ect_far_side.pulse_cnt(7, 1);
      run_chk(1'b0, 1'b0, "stop at preset");
      u_ect_far_side.pulse_cnt(0, 1);
      rd_chk(8'h40, 32'h5, "free channel frozen");
      rd_chk(8'h5c, 32'h3, "preset channel");
      u_ect_far_side.pulse_trig(0);
      run_chk(1'b0, 1'b0, "start refused at limit");
      reg_wr(`ECT_A_CTRL, 32'h8);
      u_ect_far_side.pulse_trig(0);
      run_chk(1'b1, 1'b1, "start after clear");
      u_ect_far_side.pulse_trig(1);
      $display("test count_limit done");
   endtask

   task automatic t_timer_limit();
      reg_wr(`ECT_A_MODE, 32'(time_limit_stop_cmd));
      reg_wr(`ECT_A_TPRE_LO, 32'h2);
      reg_wr(`ECT_A_TPRE_HI, 32'h0);
      reg_wr(`ECT_A_CTRL, 32'h4);
      reg_wr(`ECT_A_CTRL, 32'h1);
      run_chk(1'b1, 1'b1, "timer run");
      repeat (400) @(posedge sys_clk);
      run_chk(1'b0, 1'b0, "stop at timer preset");
      rd_chk(`ECT_A_TMR_LO, 32'h2, "timer at preset");
      reg_wr(`ECT_A_CTRL, 32'h1);
      run_chk(1'b0, 1'b0, "soft start refused");
      reg_wr(`ECT_A_MODE, 32'(no_auto_stop_cmd));
      $display("test timer_limit done");
   endtask

   // gate acquisition with timer stop armed: timer limit must not act
   task automatic t_acq();
      reg_wr(`ECT_A_CPRE, 32'h0);
      rd_chk(`ECT_A_CPRE, 32'h1, "zero preset");
      reg_wr(`ECT_A_MODE, 32'h6);
      reg_wr(`ECT_A_CTRL, 32'h24);
      reg_wr(`ECT_A_CTRL, 32'h1);
      u_ect_far_side.pulse_cnt(2, 3);
      u_ect_far_side.set_gate(1'b0);
      u_ect_far_side.pulse_cnt(2, 2);
      u_ect_far_side.set_gate(1'b1);
      repeat (300) @(posedge sys_clk);
      run_chk(1'b1, 1'b1, "timer stop off in gate acq");
      rd_chk(`ECT_A_ACQ_ADDR, 32'h2, "snapshot count");
      reg_wr(`ECT_A_ACQ_SEL, 32'h0002_0000);
      rd_chk(`ECT_A_ACQ_DATA, 32'h3, "stored channel two");
      u_ect_far_side.pulse_trig(1);
      reg_wr(`ECT_A_MODE, 32'h0);
      $display("test acq done");
   endtask

   // ce low freezes counters, synchronisers and the bus
   task automatic t_freeze();
      reg_wr(`ECT_A_CTRL, 32'h5);
      @(posedge sys_clk);
      ce <= 1'b0;
      u_ect_far_side.pulse_cnt(0, 2);
      reg_wr(`ECT_A_CTRL, 32'h2);
      @(posedge sys_clk);
      ce <= 1'b1;
      run_chk(1'b1, 1'b1, "run held across freeze");
      u_ect_far_side.pulse_cnt(0, 1);
      rd_chk(8'h40, 32'h1, "count frozen by ce");
      u_ect_far_side.pulse_trig(1);
      $display("test freeze done");
   endtask

   task automatic t_polarity();
      @(posedge sys_clk);
      bank <= 4'h6;
      run_chk(1'b1, 1'b0, "inverted run idle");
      u_ect_far_side.pulse_trig(0);
      run_chk(1'b0, 1'b1, "inverted run active");
      u_ect_far_side.pulse_trig(1);
      run_chk(1'b1, 1'b0, "inverted run stopped");
      @(posedge sys_clk);
      bank <= 4'hf;
      run_chk(1'b0, 1'b0, "polarity restored");
      $display("test polarity done");
   endtask

   // reset in mid-run: counting off, stop mode reloaded
   task automatic t_reset();
      u_ect_far_side.pulse_trig(0);
      @(posedge sys_clk);
      nv_stop_mode <= 2'(time_limit_stop_cmd);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 chk({31'h0, run_out}, 32'h0, "run in reset");
      chk({30'h0, stop_mode_out}, 32'(time_limit_stop_cmd), "mode reloaded");
      @(posedge sys_clk);
      rst <= 1'b0;
      run_chk(1'b0, 1'b0, "off after reset");
      $display("test reset done");
   endtask

   // ****************************************
   // verdict and sequencing
   // ****************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   initial
   begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      #1 chk({31'h0, run_out}, 32'h0, "run at reset");
      chk({30'h0, stop_mode_out}, 32'(no_auto_stop_cmd), "mode at reset");
      t_pins_count();
      t_gate();
      t_count_limit();
      t_timer_limit();
      t_acq();
      t_polarity();
      t_freeze();
      t_reset();
      print_verdict();
   end

   // the run needs about 1500 cycles; 20000 means a hang
   initial
   begin
      #200000;
      fail_count++;
      $display("[FAIL] %0t watchdog expired", $time);
      print_verdict();
   end
endmodule

`default_nettype wire
